/* File: include/du_pkg.sv */
// constants, field positions and types for the dual serial transceiver
package du_pkg;
  localparam int CHANNELS   = 2;
  localparam int FIFO_DEPTH = 64;
  localparam int BYTE_W     = 8;
  // register addresses, bank 0 (bank bit of line control clear)
  localparam logic [2:0] A_DATA  = 3'h0;
  localparam logic [2:0] A_IEN   = 3'h1;
  localparam logic [2:0] A_ISTAT = 3'h2;
  localparam logic [2:0] A_LCTL  = 3'h3;
  localparam logic [2:0] A_MCTL  = 3'h4;
  localparam logic [2:0] A_LSTAT = 3'h5;
  localparam logic [2:0] A_MSTAT = 3'h6;
  localparam logic [2:0] A_READY = 3'h7;
  // bank 1 (bank bit set)
  localparam logic [2:0] A_DIVLO = 3'h0;
  localparam logic [2:0] A_DIVHI = 3'h1;
  localparam logic [2:0] A_EFEAT = 3'h2;
  localparam logic [2:0] A_XON   = 3'h4;
  localparam logic [2:0] A_XOFF  = 3'h5;
  localparam logic [2:0] A_FLOW  = 3'h6;
  localparam logic [2:0] A_TRIG  = 3'h3;
  // field positions
  localparam int LC_STOP = 2;
  localparam int LC_PEN  = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_BRK  = 6;
  localparam int LC_BANK = 7;
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_OUT  = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_ANY  = 5;
  localparam int MC_PRE  = 7;
  localparam int EF_SWF  = 3;
  localparam int EF_RTS  = 6;
  localparam int EF_CTS  = 7;
  // reset values
  localparam logic [7:0]  LCTL_RST = 8'h03;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [7:0]  XON_RST  = 8'h11;
  localparam logic [7:0]  XOFF_RST = 8'h13;
  // prescaler last count in clock cycles, then timing in oversample ticks
  localparam logic [1:0] PRE_LAST   = 2'h3;
  localparam logic [5:0] BIT_TICKS  = 6'h10;
  localparam logic [5:0] HALF_TICKS = 6'h08;
  localparam logic [5:0] STOP15_TK  = 6'h18;
  localparam logic [5:0] STOP2_TK   = 6'h20;
  localparam logic [7:0] IDLE_TICKS = 8'ha0;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_DATA  = 3'b010,
    S_PAR   = 3'b011,
    S_STOP  = 3'b100
  } du_ser_state_t;
  typedef struct packed {
    logic       brk;
    logic       ferr;
    logic       perr;
    logic [7:0] data;
  } du_rx_entry_t;
endpackage

/* File: hw/du_fifo.sv */
// synchronous fifo with valid/ready on both sides and a fill count
`timescale 1ns/1ps
`default_nettype none
module du_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     wr_valid,
  output logic                          wr_ready,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic                          rd_valid,
  input  wire logic                     rd_ready,
  output logic [WIDTH-1:0]              rd_data,
  output logic [$clog2(DEPTH):0]        count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  wire              do_wr = wr_valid & wr_ready;
  wire              do_rd = rd_valid & rd_ready;

  assign wr_ready = (count < (AW+1)'(DEPTH));
  assign rd_valid = (count != '0);
  assign rd_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

/* File: hw/du_top.sv */
// dual serial transceiver: register bus, per-channel bit engines and modem lines
//
// Summary of operation
// - character length five to eight bits
// - even/odd/no parity, 1/1.5/2 stops, checked
// - 64-entry fifos each way, trigger-level interrupts
// - divisor bit clock with optional divide-by-four
// - receiver flags break, idle, framing, parity, overrun
// - transmitter flags fifo running empty
// - threshold register drives stop/resume of far end
// - one register shows all channels' ready states
// - option lets any character resume halted transmit
// - read strobe fall drives addressed register out
// - write strobe rise captures bus into register
// - only selected channels answer bus transfers
// - bit zero is lsb and sent first
// - clear-to-send readable, gates only when auto enabled
// - control bit zero drives terminal-ready low
// - control bit three enables irq, lowers user output
// - irq asserts for enabled error/data/space/modem sources
// - after reset irq floats, user outputs high
// - reset clears registers (line control 03, divisor 1, xon/xoff 11/13 excepted), outputs; serial idle
// - ring-indicator rising edge raises modem interrupt
// - carrier, data-set-ready, ring levels shown in status
// - control bit one drives request-to-send, auto flow
// - receive-ready low while data present or triggered
// - loop-back feeds transmit into receiver, ignores pin
`timescale 1ns/1ps
`default_nettype none
module du_top #(
  parameter int CHANNELS   = du_pkg::CHANNELS,
  parameter int FIFO_DEPTH = du_pkg::FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [CHANNELS-1:0] channel_select_n,
  input  wire logic [2:0]          reg_addr,
  input  wire logic                read_strobe_n,
  input  wire logic                write_strobe_n,
  input  wire logic [7:0]          data_in,
  output logic      [7:0]          data_out,
  output logic                     data_oe,
  input  wire logic [CHANNELS-1:0] serial_in,
  output logic      [CHANNELS-1:0] serial_out,
  input  wire logic [CHANNELS-1:0] clear_to_send_n,
  input  wire logic [CHANNELS-1:0] data_set_ready_n,
  input  wire logic [CHANNELS-1:0] carrier_detect_n,
  input  wire logic [CHANNELS-1:0] ring_indicator_n,
  output logic      [CHANNELS-1:0] request_to_send_n,
  output logic      [CHANNELS-1:0] terminal_ready_n,
  output logic      [CHANNELS-1:0] channel_irq,
  output logic      [CHANNELS-1:0] channel_irq_oe,
  output logic      [CHANNELS-1:0] user_output,
  output logic      [CHANNELS-1:0] transmit_ready_out,
  output logic      [CHANNELS-1:0] receive_ready_out
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // strobes are synchronous; edges found against last cycle's level
  logic rd_prev;
  logic wr_prev;
  wire  rd_fall = rd_prev & ~read_strobe_n;
  wire  wr_rise = ~wr_prev & write_strobe_n;

  logic [CHANNELS-1:0] tx_rdy_act;
  logic [CHANNELS-1:0] rx_rdy_act;
  logic [7:0]          ch_rdata [CHANNELS];
  wire  [7:0]          ready_word = 8'(tx_rdy_act) | (8'(rx_rdy_act) << 4);

  logic [7:0] sel_rdata;
  always_comb begin
    sel_rdata = 8'h00;
    for (int k = CHANNELS - 1; k >= 0; k--) begin
      if (!channel_select_n[k]) begin
        sel_rdata = ch_rdata[k];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev  <= 1'b1;
      wr_prev  <= 1'b1;
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      rd_prev <= read_strobe_n;
      wr_prev <= write_strobe_n;
      if (rd_fall && !(&channel_select_n)) begin
        data_out <= sel_rdata;
      end
      data_oe <= ~read_strobe_n & ~(&channel_select_n);
    end
  end

  // one independent copy of the serial logic per channel
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    logic [7:0]  lctl, mctl, ien, efeat, xon_c, xoff_c, flow_thr, trig;
    logic [15:0] divisor, div_cnt;
    logic [1:0]  pre_cnt;
    logic        overrun, underflow, idle_flag, sw_halt, rts_hold;
    logic [3:0]  msr_delta;
    logic [3:0]  pin_prev;
    du_pkg::du_ser_state_t tx_st, rx_st;
    logic [5:0]  tx_tk, rx_tk;
    logic [2:0]  tx_bit, rx_bit;
    logic [7:0]  tx_sh, rx_sh;
    logic        tx_line, rx_par, rx_zero, rx_armed, idle_pend;
    logic [7:0]  idle_cnt;
    logic [CW-1:0] rx_cnt, tx_cnt;
    du_pkg::du_rx_entry_t rx_head, rx_new;
    logic        rx_valid, rx_push, tx_wready, tx_valid, rx_wready_w;
    logic [7:0]  tx_head;

    wire sel    = ~channel_select_n[i];
    wire bank   = lctl[du_pkg::LC_BANK];
    wire rd_hit = rd_fall & sel;
    wire wr_hit = wr_rise & sel;
    wire wr0    = wr_hit & ~bank;
    wire wr1    = wr_hit & bank;

    // bit clock: optional prescale of four, then the divisor
    wire pre_tick = ~mctl[du_pkg::MC_PRE] | (pre_cnt == du_pkg::PRE_LAST);
    wire tick     = pre_tick & (div_cnt <= 16'h0001);

    // character format
    wire [2:0] last_bit = {1'b1, lctl[1:0]};
    wire [7:0] len_mask = 8'hff >> (3'h3 - {1'b0, lctl[1:0]});
    wire [5:0] stop_tk  = !lctl[du_pkg::LC_STOP] ? du_pkg::BIT_TICKS :
                          (lctl[1:0] == 2'h0) ? du_pkg::STOP15_TK : du_pkg::STOP2_TK;
    wire       tx_par   = ^(tx_sh & len_mask) ^ ~lctl[du_pkg::LC_EVEN];
    wire       rx_pexp  = ^(rx_sh & len_mask) ^ ~lctl[du_pkg::LC_EVEN];

    // loop-back ignores the pin and hears our own transmitter
    wire rx_in  = mctl[du_pkg::MC_LOOP] ? tx_line : serial_in[i];
    wire cts_ok = ~efeat[du_pkg::EF_CTS] | ~clear_to_send_n[i];
    wire tx_go  = tick & (tx_st == du_pkg::S_IDLE) & tx_valid & cts_ok & ~sw_halt;
    wire tx_end = tick & (tx_st == du_pkg::S_STOP) & (tx_tk == stop_tk - 6'h01);
    wire smp    = tick & (rx_tk == du_pkg::BIT_TICKS - 6'h01);

    // fifo levels
    wire [CW-1:0] rx_trig = (trig[3:0] == 4'h0) ? CW'(1) : CW'({trig[3:0], 2'b00});
    wire [CW-1:0] tx_trig = (trig[7:4] == 4'h0) ? CW'(1) : CW'({trig[7:4], 2'b00});
    wire [CW-1:0] halt_lv = CW'({flow_thr[3:0], 2'b00});
    wire [CW-1:0] resm_lv = CW'({flow_thr[7:4], 2'b00});
    wire [CW-1:0] tx_free = CW'(FIFO_DEPTH) - tx_cnt;

    // received control characters under software flow
    wire swf      = efeat[du_pkg::EF_SWF];
    wire is_xoff  = swf & (rx_new.data == xoff_c);
    wire is_xon   = swf & (rx_new.data == xon_c);
    wire stop_ok  = smp & (rx_st == du_pkg::S_STOP);
    assign rx_new = '{brk: rx_zero & ~rx_in, ferr: ~rx_in, perr: rx_par,
                      data: rx_sh & len_mask};
    assign rx_push = stop_ok & ~is_xoff & ~is_xon;

    // interrupt sources
    wire src_err  = overrun | (rx_valid & (rx_head.perr | rx_head.ferr | rx_head.brk));
    wire src_data = (rx_cnt >= rx_trig);
    wire src_tx   = (tx_free >= tx_trig);
    wire src_mdm  = |msr_delta;
    wire [3:0] src = {src_mdm, src_err, src_tx, src_data};
    wire irq_lvl  = |(ien[3:0] & src);

    wire [7:0] lstat = {underflow, tx_st == du_pkg::S_IDLE && !tx_valid, !tx_valid,
                        rx_valid & rx_head.brk, rx_valid & rx_head.ferr,
                        rx_valid & rx_head.perr, overrun, rx_valid};
    wire [7:0] mstat = {~carrier_detect_n[i], ~ring_indicator_n[i], ~data_set_ready_n[i],
                        ~clear_to_send_n[i], msr_delta};
    wire [7:0] istat = {underflow, idle_flag, 2'b00, src};

    always_comb begin
      case (reg_addr)
        du_pkg::A_DATA:  ch_rdata[i] = bank ? divisor[7:0] : rx_head.data;
        du_pkg::A_IEN:   ch_rdata[i] = bank ? divisor[15:8] : ien;
        du_pkg::A_ISTAT: ch_rdata[i] = bank ? efeat : istat;
        du_pkg::A_LCTL:  ch_rdata[i] = bank ? trig : lctl;
        du_pkg::A_MCTL:  ch_rdata[i] = bank ? xon_c : mctl;
        du_pkg::A_LSTAT: ch_rdata[i] = bank ? xoff_c : lstat;
        du_pkg::A_MSTAT: ch_rdata[i] = bank ? flow_thr : mstat;
        default:         ch_rdata[i] = ready_word;
      endcase
    end

    // register writes; bank 1 slot 3 is the trigger register
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lctl     <= du_pkg::LCTL_RST;
        mctl     <= 8'h00;
        ien      <= 8'h00;
        efeat    <= 8'h00;
        xon_c    <= du_pkg::XON_RST;
        xoff_c   <= du_pkg::XOFF_RST;
        flow_thr <= 8'h00;
        trig     <= 8'h00;
        divisor  <= du_pkg::DIV_RST;
      end else if (wr_hit) begin
        if (reg_addr == du_pkg::A_LCTL && !bank) lctl <= data_in;
        if (reg_addr == du_pkg::A_LCTL && bank && data_in[du_pkg::LC_BANK]) lctl <= data_in;
        if (reg_addr == du_pkg::A_LCTL && bank && !data_in[du_pkg::LC_BANK]) begin
          trig <= data_in;
        end
        if (wr0 && reg_addr == du_pkg::A_IEN)   ien      <= data_in;
        if (wr0 && reg_addr == du_pkg::A_MCTL)  mctl     <= data_in;
        if (wr1 && reg_addr == du_pkg::A_DIVLO) divisor[7:0]  <= data_in;
        if (wr1 && reg_addr == du_pkg::A_DIVHI) divisor[15:8] <= data_in;
        if (wr1 && reg_addr == du_pkg::A_EFEAT) efeat    <= data_in;
        if (wr1 && reg_addr == du_pkg::A_XON)   xon_c    <= data_in;
        if (wr1 && reg_addr == du_pkg::A_XOFF)  xoff_c   <= data_in;
        if (wr1 && reg_addr == du_pkg::A_FLOW)  flow_thr <= data_in;
      end
    end

    // bit-rate generator
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pre_cnt <= 2'h0;
        div_cnt <= du_pkg::DIV_RST;
      end else begin
        pre_cnt <= pre_cnt + 2'h1;
        if (pre_tick) begin
          div_cnt <= tick ? divisor : div_cnt - 16'h0001;
        end
      end
    end

    // transmitter: lsb first, optional parity, programmed stop length
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        tx_st   <= du_pkg::S_IDLE;
        tx_tk   <= 6'h00;
        tx_bit  <= 3'h0;
        tx_sh   <= 8'h00;
        tx_line <= 1'b1;
      end else if (tx_go) begin
        tx_st   <= du_pkg::S_START;
        tx_sh   <= tx_head;
        tx_tk   <= 6'h00;
        tx_line <= 1'b0;
      end else if (tick && tx_st != du_pkg::S_IDLE) begin
        tx_tk <= tx_tk + 6'h01;
        if (tx_st != du_pkg::S_STOP && tx_tk == du_pkg::BIT_TICKS - 6'h01) begin
          tx_tk <= 6'h00;
          case (tx_st)
            du_pkg::S_START: begin
              tx_st   <= du_pkg::S_DATA;
              tx_bit  <= 3'h0;
              tx_line <= tx_sh[0];
            end
            du_pkg::S_DATA: begin
              tx_bit <= tx_bit + 3'h1;
              if (tx_bit == last_bit) begin
                tx_st   <= lctl[du_pkg::LC_PEN] ? du_pkg::S_PAR : du_pkg::S_STOP;
                tx_line <= lctl[du_pkg::LC_PEN] ? tx_par : 1'b1;
              end else begin
                tx_line <= tx_sh[tx_bit + 3'h1];
              end
            end
            default: begin
              tx_st   <= du_pkg::S_STOP;
              tx_line <= 1'b1;
            end
          endcase
        end else if (tx_end) begin
          tx_st <= du_pkg::S_IDLE;
        end
      end
    end

    // receiver: start confirmed at mid-bit, then one sample per bit centre
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rx_st    <= du_pkg::S_IDLE;
        rx_tk    <= 6'h00;
        rx_bit   <= 3'h0;
        rx_sh    <= 8'h00;
        rx_par   <= 1'b0;
        rx_zero  <= 1'b0;
        rx_armed <= 1'b0;
      end else if (tick) begin
        rx_tk <= smp ? 6'h00 : rx_tk + 6'h01;
        case (rx_st)
          du_pkg::S_IDLE: begin
            rx_armed <= rx_in;
            if (rx_armed && !rx_in) begin
              rx_st <= du_pkg::S_START;
              rx_tk <= du_pkg::HALF_TICKS;
            end
          end
          du_pkg::S_START: if (smp) begin
            // a glitch shorter than half a bit is no start
            rx_st   <= rx_in ? du_pkg::S_IDLE : du_pkg::S_DATA;
            rx_bit  <= 3'h0;
            rx_sh   <= 8'h00;
            rx_par  <= 1'b0;
            rx_zero <= 1'b1;
          end
          du_pkg::S_DATA: if (smp) begin
            rx_sh[rx_bit] <= rx_in;
            rx_zero       <= rx_zero & ~rx_in;
            rx_bit        <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_st <= lctl[du_pkg::LC_PEN] ? du_pkg::S_PAR : du_pkg::S_STOP;
            end
          end
          du_pkg::S_PAR: if (smp) begin
            rx_par  <= rx_in ^ rx_pexp;
            rx_zero <= rx_zero & ~rx_in;
            rx_st   <= du_pkg::S_STOP;
          end
          du_pkg::S_STOP: if (smp) begin
            rx_st    <= du_pkg::S_IDLE;
            rx_armed <= rx_in;  // a break must end before the next start
          end
          default: rx_st <= du_pkg::S_IDLE;
        endcase
      end
    end

    // sticky status; a setting event beats a clearing read
    wire rd_istat = rd_hit & ~bank & (reg_addr == du_pkg::A_ISTAT);
    wire rd_lstat = rd_hit & ~bank & (reg_addr == du_pkg::A_LSTAT);
    wire rd_mstat = rd_hit & ~bank & (reg_addr == du_pkg::A_MSTAT);
    wire [3:0] pins_now = {carrier_detect_n[i], ring_indicator_n[i],
                           data_set_ready_n[i], clear_to_send_n[i]};
    wire [3:0] chg = {pins_now[3] ^ pin_prev[3], ~pin_prev[2] & pins_now[2],
                      pins_now[1:0] ^ pin_prev[1:0]};
    wire idle_hit = tick & idle_pend & (rx_st == du_pkg::S_IDLE) & rx_in
                    & (idle_cnt == du_pkg::IDLE_TICKS);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        overrun   <= 1'b0;
        underflow <= 1'b0;
        idle_flag <= 1'b0;
        idle_pend <= 1'b0;
        idle_cnt  <= 8'h00;
        msr_delta <= 4'h0;
        pin_prev  <= 4'hf;
        sw_halt   <= 1'b0;
        rts_hold  <= 1'b0;
      end else begin
        pin_prev  <= pins_now;
        overrun   <= (rx_push & ~rx_wready_w) | (overrun & ~rd_lstat);
        underflow <= (tx_end & ~tx_valid) | (underflow & ~rd_istat);
        idle_flag <= idle_hit | (idle_flag & ~rd_istat);
        msr_delta <= {chg[3], chg[2], chg[1], chg[0]} | (msr_delta & ~{4{rd_mstat}});
        if (stop_ok) begin
          idle_pend <= 1'b1;
          idle_cnt  <= 8'h00;
        end else if (idle_hit) begin
          idle_pend <= 1'b0;
        end else if (tick && idle_pend) begin
          idle_cnt <= (rx_st == du_pkg::S_IDLE && rx_in) ? idle_cnt + 8'h01 : 8'h00;
        end
        if (stop_ok && is_xoff) begin
          sw_halt <= 1'b1;
        end else if (stop_ok && (is_xon || (mctl[du_pkg::MC_ANY] && sw_halt))) begin
          sw_halt <= 1'b0;
        end
        if (halt_lv != '0 && rx_cnt >= halt_lv) begin
          rts_hold <= 1'b1;
        end else if (rx_cnt <= resm_lv) begin
          rts_hold <= 1'b0;
        end
      end
    end

    du_fifo #(.WIDTH($bits(du_pkg::du_rx_entry_t)), .DEPTH(FIFO_DEPTH)) u_rxf (
      .clk      (clk),
      .rst_n    (rst_n),
      .wr_valid (rx_push),
      .wr_ready (rx_wready_w),
      .wr_data  (rx_new),
      .rd_valid (rx_valid),
      .rd_ready (rd_hit & ~bank & (reg_addr == du_pkg::A_DATA)),
      .rd_data  (rx_head),
      .count    (rx_cnt)
    );
    du_fifo #(.WIDTH(du_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_txf (
      .clk      (clk),
      .rst_n    (rst_n),
      .wr_valid (wr0 & (reg_addr == du_pkg::A_DATA)),
      .wr_ready (tx_wready),
      .wr_data  (data_in),
      .rd_valid (tx_valid),
      .rd_ready (tx_go),
      .rd_data  (tx_head),
      .count    (tx_cnt)
    );

    assign tx_rdy_act[i] = tx_wready & (src_tx | ~tx_valid);
    assign rx_rdy_act[i] = rx_valid | src_data;

    // pin outputs, all registered
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        serial_out[i]         <= 1'b1;
        request_to_send_n[i]  <= 1'b1;
        terminal_ready_n[i]   <= 1'b1;
        channel_irq[i]        <= 1'b0;
        channel_irq_oe[i]     <= 1'b0;
        user_output[i]        <= 1'b1;
        transmit_ready_out[i] <= 1'b1;
        receive_ready_out[i]  <= 1'b1;
      end else begin
        serial_out[i] <= mctl[du_pkg::MC_LOOP] | (tx_line & ~lctl[du_pkg::LC_BRK]);
        request_to_send_n[i] <= ~(mctl[du_pkg::MC_RTS]
                                  & ~(efeat[du_pkg::EF_RTS] & rts_hold));
        terminal_ready_n[i]   <= ~mctl[du_pkg::MC_DTR];
        channel_irq[i]        <= mctl[du_pkg::MC_OUT] & irq_lvl;
        channel_irq_oe[i]     <= mctl[du_pkg::MC_OUT];
        user_output[i]        <= ~mctl[du_pkg::MC_OUT];
        transmit_ready_out[i] <= ~tx_rdy_act[i];
        receive_ready_out[i]  <= ~rx_rdy_act[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/du_top_asserts.sv */
// concurrent checks on the dual transceiver pins
`timescale 1ns/1ps
`default_nettype none
module du_top_asserts #(
  parameter int CHANNELS = 2
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [CHANNELS-1:0] channel_select_n,
  input wire logic                read_strobe_n,
  input wire logic                write_strobe_n,
  input wire logic [7:0]          data_out,
  input wire logic                data_oe,
  input wire logic [CHANNELS-1:0] serial_out,
  input wire logic [CHANNELS-1:0] terminal_ready_n,
  input wire logic [CHANNELS-1:0] channel_irq_oe,
  input wire logic [CHANNELS-1:0] user_output,
  input wire logic [CHANNELS-1:0] transmit_ready_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       rd_q;
  logic       wr_q;
  logic [2:0] wr_age;
  wire logic  rd_take = rd_q && !read_strobe_n && (channel_select_n != '1);
  // age saturates so a stale write never excuses a late output change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= 1'b1;
      wr_q   <= 1'b1;
      wr_age <= 3'h7;
    end else begin
      rd_q   <= read_strobe_n;
      wr_q   <= write_strobe_n;
      wr_age <= (write_strobe_n && !wr_q) ? 3'h0 : (wr_age == 3'h7 ? wr_age : wr_age + 3'h1);
    end
  end
  AST_RD_DRIVE: assert property (rd_take |=> data_oe)
    else $error("read strobe fall did not drive the bus");
  AST_RD_IDLE: assert property (read_strobe_n |=> !data_oe)
    else $error("bus driven without read strobe");
  AST_NO_SEL: assert property (channel_select_n == '1 |=> !data_oe)
    else $error("bus driven with no channel selected");
  AST_DOUT_HOLD: assert property (!rd_take |=> $stable(data_out))
    else $error("read data changed without a read");
  AST_RST_OUT: assert property ($rose(rst_n) |-> serial_out == '1 && user_output == '1
    && channel_irq_oe == '0 && terminal_ready_n == '1 && !data_oe)
    else $error("outputs not at reset levels");
  AST_OUT_MODE: assert property (channel_irq_oe == ~user_output)
    else $error("irq enable and user output disagree");
  AST_DTR_WR: assert property ($changed(terminal_ready_n) |-> wr_age < 3'h3)
    else $error("terminal ready moved without a write");
  AST_USR_WR: assert property ($changed(user_output) |-> wr_age < 3'h3)
    else $error("user output moved without a write");
  AST_TRANSMIT_READY_OUT_WR: assert property ((transmit_ready_out & ~$past(transmit_ready_out)) != '0
    |-> wr_age < 3'h4)
    else $error("transmit ready dropped without a write");
  cover property (rd_take);
  cover property ($fell(terminal_ready_n[0]));
  cover property ($rose(transmit_ready_out[1]));
endmodule
bind du_top du_top_asserts #(.CHANNELS(CHANNELS)) du_top_asserts_i (.clk, .rst_n,
  .channel_select_n, .read_strobe_n, .write_strobe_n, .data_out, .data_oe, .serial_out,
  .terminal_ready_n, .channel_irq_oe, .user_output, .transmit_ready_out);
`default_nettype wire

/* File: verification/du_host.sv */
// host cpu model for the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module du_host (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  output logic      [1:0] channel_select_n,
  output logic      [2:0] reg_addr,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic      [7:0] data_in
);
  initial begin
    channel_select_n = 2'h3;
    reg_addr = 3'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = 8'h00;
  end
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) #1 channel_select_n = s;
    reg_addr = a;
    data_in = d;
    write_strobe_n = 1'b0;
    @(posedge clk) #1 write_strobe_n = 1'b1;
    @(posedge clk) #1 channel_select_n = 2'h3;
    data_in = ~d;
  endtask
  task automatic rd(input logic [1:0] s, input logic [2:0] a, output logic [7:0] q);
    @(posedge clk) #1 channel_select_n = s;
    reg_addr = a;
    read_strobe_n = 1'b0;
    @(posedge clk);
    @(posedge clk) #1 q = data_out;
    read_strobe_n = 1'b1;
    channel_select_n = 2'h3;
  endtask
endmodule
`default_nettype wire

/* File: verification/du_top_tb.sv */
// self-checking bench for the dual serial transceiver
`timescale 1ns/1ps
`default_nettype none
module du_top_tb;
  logic       clk, rst_n, read_strobe_n, write_strobe_n, data_oe;
  logic [1:0] channel_select_n, serial_in, serial_out, clear_to_send_n, data_set_ready_n;
  logic [1:0] carrier_detect_n, ring_indicator_n, request_to_send_n, terminal_ready_n;
  logic [1:0] channel_irq, channel_irq_oe, user_output, transmit_ready_out, receive_ready_out;
  logic [2:0] reg_addr;
  logic [7:0] data_in, data_out, q;
  logic [9:0] fr;
  int         miscompares, n_checks, i;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  du_host du_host_i (.clk, .data_out, .channel_select_n, .reg_addr, .read_strobe_n,
    .write_strobe_n, .data_in);
  du_top du_top_i (.clk, .rst_n, .channel_select_n, .reg_addr, .read_strobe_n, .write_strobe_n,
    .data_in, .data_out, .data_oe, .serial_in, .serial_out, .clear_to_send_n, .data_set_ready_n,
    .carrier_detect_n, .ring_indicator_n, .request_to_send_n, .terminal_ready_n, .channel_irq,
    .channel_irq_oe, .user_output, .transmit_ready_out, .receive_ready_out);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic w(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    du_host_i.wr(s, a, d);
    settle;
  endtask
  task automatic rdc(input logic [1:0] s, input logic [2:0] a, input logic [7:0] e);
    du_host_i.rd(s, a, q);
    chk(q, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // far end held idle; modem lines start inactive
  initial begin
    miscompares = 0;
    n_checks = 0;
    rst_n = 1'b0;
    serial_in = 2'h3;
    clear_to_send_n = 2'h3;
    data_set_ready_n = 2'h3;
    carrier_detect_n = 2'h3;
    ring_indicator_n = 2'h3;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    rdc(2'h2, du_pkg::A_READY, 8'h03);
    w(2'h2, du_pkg::A_MCTL, 8'h0b);
    chk({2'h0, terminal_ready_n, user_output, channel_irq_oe}, 8'h29);
    chk({6'h0, request_to_send_n}, 8'h02);
    carrier_detect_n = 2'h2;
    data_set_ready_n = 2'h2;
    clear_to_send_n = 2'h2;
    settle;
    rdc(2'h2, du_pkg::A_MSTAT, 8'hbb);
    rdc(2'h2, du_pkg::A_MSTAT, 8'hb0);
    w(2'h2, du_pkg::A_IEN, 8'h08);
    ring_indicator_n = 2'h2;
    settle;
    chk({6'h0, channel_irq}, 8'h00);
    ring_indicator_n = 2'h3;
    settle;
    chk({6'h0, channel_irq}, 8'h01);
    rdc(2'h2, du_pkg::A_MSTAT, 8'hb4);
    settle;
    chk({6'h0, channel_irq}, 8'h00);
    w(2'h2, du_pkg::A_MCTL, 8'h10);
    chk({2'h0, terminal_ready_n, user_output, channel_irq_oe}, 8'h3c);
    chk({6'h0, request_to_send_n}, 8'h03);
    serial_in = 2'h2;
    w(2'h2, du_pkg::A_DATA, 8'ha5);
    repeat (80) @(posedge clk);
    #1 chk({6'h0, serial_out}, 8'h03);
    repeat (200) @(posedge clk);
    rdc(2'h2, du_pkg::A_READY, 8'h13);
    chk({6'h0, receive_ready_out}, 8'h02);
    chk({6'h0, transmit_ready_out}, 8'h00);
    rdc(2'h2, du_pkg::A_DATA, 8'ha5);
    settle;
    chk({6'h0, receive_ready_out}, 8'h03);
    du_host_i.wr(2'h1, du_pkg::A_DATA, 8'h96);
    for (i = 0; i < 50 && serial_out[1]; i++) @(posedge clk) #1;
    fr = {1'b1, 8'h96, 1'b0};
    // sample each bit at its middle, start bit first
    for (i = 0; i < 10; i++) begin
      repeat (i == 0 ? 8 : 16) @(posedge clk);
      #1 chk({7'h0, serial_out[1]}, {7'h0, fr[i]});
    end
    // writes outpace the line, so the fifo fills and the extras drop
    for (i = 0; i < 70; i++) begin
      du_host_i.wr(2'h1, du_pkg::A_DATA, 8'h5a);
    end
    rdc(2'h2, du_pkg::A_READY, 8'h01);
    chk({6'h0, transmit_ready_out}, 8'h02);
    summarize;
  end
  // a run needs about 730 cycles; this bound of 30000 cycles is about forty times that
  initial begin
    #300000;
    miscompares++;
    summarize;
  end
endmodule
`default_nettype wire
